// ==== lcd_host_port_command_decoder.sv ====
/*
 * Host parallel port and command decoder of a 128x64 dot-matrix display
 * controller: pin synchronisers, both bus styles, command decoding,
 * panel settings, display memory with a host port and a scan port.
 * Assumes host pins are asynchronous to SYS_CLK and that the scan
 * port is driven by panel logic on SYS_CLK.
 */
// Behaviour
// R01: Transfers only while chip select is low.
// R02: Data/command select high means memory data.
// R03: Strobe pair: latch byte at write rising.
// R04: Strobe pair: drive bus only while read low.
// R05: Hardware reset low holds settings initialised.
// R06: Strap high selects enable plus direction.
// R07: Display on/off from command bit 0.
// R08: Start-line command loads top line.
// R09: Page command loads page pointer.
// R10: Two commands load column upper, lower nibble.
// R11: Control read returns status byte.
// R12: Data write stores, data read returns memory.
// R13: Segment direction bit reverses column mapping.
// R14: Reverse bit inverts every shown pixel.
// R15: All-points bit forces every pixel on.
// R16: Bias bit selects 1/9 or 1/7.
// R17: Read-modify-write: increment on writes only.
// R18: Software reset command reinitialises settings; display on, segment direction, inversion and all-points are kept.
// R19: Common direction bit reverses scan.
// R20: Power control loads operating mode.
// R21: Volume mode then contrast byte.
// R22: Indicator on/off then flashing mode byte.
// R23: Otherwise column increments after data access.
// R24: Enable style: direction line, enable high.
`timescale 1ns/10ps
module lcd_host_port_command_decoder
	import lcd_port_pkg::*;
#(
	parameter int PAGES = 8,
	parameter int COLUMNS = 128
)
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CHIP_SELECT_N,
	input wire logic DATA_COMMAND_SELECT,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic BUS_STYLE_STRAP,
	input wire logic HARDWARE_RESET_N,
	input wire logic [7:0] HOST_DATA_IN,
	output logic [7:0] HOST_DATA_OUT,
	output logic HOST_DATA_OE,
	output panel_settings_t SETTINGS,
	output logic [PAGE_W-1:0] PAGE_ADDRESS,
	output logic [COL_W-1:0] COLUMN_ADDRESS,
	output logic RMW_ACTIVE,
	input wire logic [PAGE_W-1:0] SCAN_PAGE,
	input wire logic [COL_W-1:0] SCAN_COLUMN,
	output logic [7:0] SCAN_DATA
);
	// Memory geometry derived from the parameters.
	localparam int DEPTH = PAGES * COLUMNS;
	localparam int AW = $clog2(DEPTH);
	localparam logic [COL_W-1:0] LAST_COL = COL_W'(COLUMNS - 1);
	// Pin group: chip select, d/c, two strobes, strap, reset, data.
	// Idle is deselected, control, both strobes high, strap low and the
	// reset pin released, so no false strobe or reset follows SYS_RST.
	localparam logic [13:0] PIN_IDLE = 14'h2D00;
	// True when a byte matches an opcode under its mask.
	function automatic logic hit(input logic [7:0] b, input logic [7:0] op,
		input logic [7:0] mask);
		hit = (b & mask) == op;
	endfunction : hit
	// Synchronised pins.
	logic cs_n_s, dc_s, wr_n_s, rd_n_s, strap_s, hw_rst_n_s;
	logic [7:0] data_s;
	// Every host pin is asynchronous, so all pass two flip-flops.
	pin_sync #(.W(14), .RESET_VALUE(PIN_IDLE)) u_pin_sync (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.pin_in({CHIP_SELECT_N, DATA_COMMAND_SELECT, WRITE_STROBE_N,
			READ_STROBE_N, BUS_STYLE_STRAP, HARDWARE_RESET_N, HOST_DATA_IN}),
		.pin_out({cs_n_s, dc_s, wr_n_s, rd_n_s, strap_s, hw_rst_n_s, data_s})
	);
	// Strobe history and the byte seen while the strobe was active.
	logic wr_act_reg, rd_act_reg, dc_prev_reg;
	logic [7:0] data_prev_reg;
	// Decoder and addressing state with their next values.
	cmd_state_t state_reg, state_next;
	logic [PAGE_W-1:0] page_reg, page_next;
	logic [COL_W-1:0] column_reg, column_next;
	logic rmw_reg, rmw_next;
	panel_settings_t settings_reg, settings_next;
	// Host read path and scan output.
	logic [7:0] dout_reg, scan_reg;
	logic oe_reg;
	// Display memory, one byte per page and column.
	logic [7:0] ram [DEPTH];
	// R01 chip select gate
	wire sel = ~cs_n_s;
	// R06 bus style select
	// R24 enable with direction
	// In enable style the write pin carries direction (high reads) and
	// the read pin carries the active-high enable.
	wire wr_act = sel & (strap_s ? (rd_n_s & ~wr_n_s) : ~wr_n_s);
	wire rd_act = sel & (strap_s ? (rd_n_s & wr_n_s) : ~rd_n_s);
	// R03 latch at strobe end
	// The write is taken when the strobe leaves its active level, using
	// the byte sampled one cycle earlier while it was still active.
	wire wr_event = wr_act_reg & ~wr_act;
	wire rd_start = rd_act & ~rd_act_reg;
	wire rd_end = rd_act_reg & ~rd_act;
	// R02 data or control
	wire data_wr = wr_event & dc_prev_reg;
	wire ctrl_wr = wr_event & ~dc_prev_reg;
	wire data_rd_end = rd_end & dc_prev_reg;
	wire is_cmd = ctrl_wr & (state_reg == ST_COMMAND);
	wire second_byte = ctrl_wr & (state_reg != ST_COMMAND);
	wire [7:0] b = data_prev_reg;
	// Command decode, one named wire per command.
	wire c_disp = is_cmd & hit(b, OP_DISPLAY_ONOFF, MASK_BIT0);
	wire c_line = is_cmd & hit(b, OP_START_LINE, MASK_TOP2);
	wire c_page = is_cmd & hit(b, OP_PAGE, MASK_NIBBLE);
	wire c_col_hi = is_cmd & hit(b, OP_COL_UPPER, MASK_NIBBLE);
	wire c_col_lo = is_cmd & hit(b, OP_COL_LOWER, MASK_NIBBLE);
	wire c_seg = is_cmd & hit(b, OP_SEG_DIR, MASK_BIT0);
	wire c_inv = is_cmd & hit(b, OP_INVERT, MASK_BIT0);
	wire c_all = is_cmd & hit(b, OP_ALL_POINTS, MASK_BIT0);
	wire c_bias = is_cmd & hit(b, OP_BIAS, MASK_BIT0);
	wire c_rmw = is_cmd & hit(b, OP_RMW, MASK_ALL);
	wire c_end = is_cmd & hit(b, OP_END, MASK_ALL);
	wire c_reset = is_cmd & hit(b, OP_SOFT_RESET, MASK_ALL);
	wire c_com = is_cmd & hit(b, OP_COM_DIR, MASK_NIBBLE);
	wire c_power = is_cmd & hit(b, OP_POWER, MASK_TOP5);
	wire c_ratio = is_cmd & hit(b, OP_RATIO, MASK_TOP5);
	wire c_volume = is_cmd & hit(b, OP_VOLUME_MODE, MASK_ALL);
	wire c_ind = is_cmd & hit(b, OP_INDICATOR, MASK_BIT0);
	// Host address into the memory; out-of-range writes are dropped and reads return 00.
	wire host_ok = (int'(page_reg) < PAGES) && (int'(column_reg) < COLUMNS);
	wire [AW-1:0] host_idx = AW'(int'(page_reg) * COLUMNS + int'(column_reg));
	// The column stops at the last one rather than wrapping to page start.
	wire [COL_W-1:0] col_inc = (column_reg < LAST_COL) ? column_reg + 8'h01
		: column_reg;
	// R11 status byte
	// Busy never shows: every command completes within one clock.
	wire [7:0] status_byte = (8'h00
		| ({7'h00, settings_reg.seg_reverse} << STAT_SEG_DIR_BIT)
		| ({7'h00, ~settings_reg.display_on} << STAT_OFF_BIT)
		| ({7'h00, ~hw_rst_n_s} << STAT_RESET_BIT));
	// R13 segment mapping
	wire [COL_W-1:0] scan_col = settings_reg.seg_reverse ? LAST_COL - SCAN_COLUMN
		: SCAN_COLUMN;
	wire scan_ok = (int'(SCAN_PAGE) < PAGES) && (int'(SCAN_COLUMN) < COLUMNS);
	wire [AW-1:0] scan_idx = AW'(int'(SCAN_PAGE) * COLUMNS + int'(scan_col));
	// Next panel settings from the decoded command.
	always_comb
	begin
		settings_next = settings_reg;
		// R18 software reset
		// The display mode bits survive it; the rest returns to reset values.
		if (c_reset)
		begin
			settings_next = SETTINGS_RESET;
			settings_next.display_on = settings_reg.display_on;
			settings_next.seg_reverse = settings_reg.seg_reverse;
			settings_next.invert = settings_reg.invert;
			settings_next.all_points = settings_reg.all_points;
		end
		// R07 display on/off
		if (c_disp)
			settings_next.display_on = b[0];
		// R08 start line
		if (c_line)
			settings_next.start_line = b[5:0];
		// R13 segment direction
		if (c_seg)
			settings_next.seg_reverse = b[0];
		// R14 pixel inversion
		if (c_inv)
			settings_next.invert = b[0];
		// R15 all points on
		if (c_all)
			settings_next.all_points = b[0];
		// R16 bias ratio
		if (c_bias)
			settings_next.bias_select = b[0];
		// R19 common direction
		if (c_com)
			settings_next.common_reverse = b[COM_DIR_BIT];
		// R20 power mode
		if (c_power)
			settings_next.power_mode = b[2:0];
		// Resistor ratio for the drive-level regulator.
		if (c_ratio)
			settings_next.resistor_ratio = b[2:0];
		// R22 indicator switch
		if (c_ind)
			settings_next.indicator_on = b[0];
		// R21 contrast byte
		if (second_byte && state_reg == ST_VOLUME)
			settings_next.contrast = b[5:0];
		// R22 flashing mode byte
		if (second_byte && state_reg == ST_INDICATOR)
			settings_next.indicator_mode = b[1:0];
	end

	// Next decoder state: two-byte commands wait for their operand.
	always_comb
	begin
		case (state_reg)
			ST_COMMAND:
			begin
				// R21 volume mode set
				if (c_volume)
					state_next = ST_VOLUME;
				else if (c_ind)
					state_next = ST_INDICATOR;
				else
					state_next = ST_COMMAND;
			end
			ST_VOLUME, ST_INDICATOR:
			begin
				// Any control byte is taken as the operand.
				state_next = ctrl_wr ? ST_COMMAND : state_reg;
			end
			default:
			begin
				state_next = ST_COMMAND;
			end
		endcase
	end

	// Next page, column and read-modify-write flag.
	always_comb
	begin
		page_next = page_reg;
		column_next = column_reg;
		rmw_next = rmw_reg;
		// R09 page pointer
		if (c_page)
			page_next = b[PAGE_W-1:0];
		// R10 column nibbles
		if (c_col_hi)
			column_next[7:4] = b[3:0];
		if (c_col_lo)
			column_next[3:0] = b[3:0];
		// R17 increment on writes
		if (data_wr)
			column_next = col_inc;
		// R23 increment on reads
		if (data_rd_end && !rmw_reg)
			column_next = col_inc;
		// R17 enter and end mode
		if (c_rmw)
			rmw_next = 1'b1;
		if (c_end)
			rmw_next = 1'b0;
		// A software reset returns addressing to its start.
		if (c_reset)
		begin
			page_next = PAGE_RESET;
			column_next = COL_RESET;
			rmw_next = 1'b0;
		end
	end

	// Strobe history for edge detection.
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			wr_act_reg <= 1'b0;
			rd_act_reg <= 1'b0;
			dc_prev_reg <= 1'b0;
			data_prev_reg <= 8'h00;
		end
		else
		begin
			wr_act_reg <= wr_act;
			rd_act_reg <= rd_act;
			dc_prev_reg <= dc_s;
			data_prev_reg <= data_s;
		end
	end

	// R05 level reset
	// The reset pin acts by level: settings stay initial while it is low.
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			settings_reg <= SETTINGS_RESET;
			state_reg <= ST_COMMAND;
			page_reg <= PAGE_RESET;
			column_reg <= COL_RESET;
			rmw_reg <= 1'b0;
		end
		else if (!hw_rst_n_s)
		begin
			settings_reg <= SETTINGS_RESET;
			state_reg <= ST_COMMAND;
			page_reg <= PAGE_RESET;
			column_reg <= COL_RESET;
			rmw_reg <= 1'b0;
		end
		else
		begin
			settings_reg <= settings_next;
			state_reg <= state_next;
			page_reg <= page_next;
			column_reg <= column_next;
			rmw_reg <= rmw_next;
		end
	end

	// R12 memory write
	// The memory has no reset; its contents survive both resets.
	always_ff @(posedge SYS_CLK)
	begin
		if (data_wr && host_ok)
			ram[host_idx] <= data_prev_reg;
	end

	// R04 drive during read
	// The read byte is fetched at the start of the strobe and held.
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			dout_reg <= 8'h00;
			oe_reg <= 1'b0;
		end
		else
		begin
			oe_reg <= rd_act;
			// R11 status or R12 memory byte
			if (rd_start)
				dout_reg <= dc_s ? (host_ok ? ram[host_idx] : 8'h00) : status_byte;
		end
	end

	// Scan port: one shown byte per cycle for the panel drivers.
	// Priority: display off blanks, all-points forces on, then inversion.
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			scan_reg <= 8'h00;
		else if (!settings_reg.display_on)
			scan_reg <= 8'h00;
		// R15 forced pixels
		else if (settings_reg.all_points)
			scan_reg <= 8'hFF;
		// R14 inverted pixels
		else
			scan_reg <= (scan_ok ? ram[scan_idx] : 8'h00) ^ {8{settings_reg.invert}};
	end

	// Outputs come straight from flip-flops.
	assign HOST_DATA_OUT = dout_reg;
	assign HOST_DATA_OE = oe_reg;
	assign SETTINGS = settings_reg;
	assign PAGE_ADDRESS = page_reg;
	assign COLUMN_ADDRESS = column_reg;
	assign RMW_ACTIVE = rmw_reg;
	assign SCAN_DATA = scan_reg;

endmodule : lcd_host_port_command_decoder

// ==== lcd_port_pkg.sv ====
/*
 * Shared constants and types for the display controller host port:
 * command opcodes and match masks, field widths, status bit positions,
 * reset values of the panel settings and the command decoder states.
 * Assumes nothing of its surroundings; the decoder, checker and bench import it.
 */
package lcd_port_pkg;

	// Match masks: a command hits when (byte & mask) equals its opcode.
	localparam logic [7:0] MASK_BIT0 = 8'hFE;
	localparam logic [7:0] MASK_NIBBLE = 8'hF0;
	localparam logic [7:0] MASK_TOP2 = 8'hC0;
	localparam logic [7:0] MASK_TOP5 = 8'hF8;
	localparam logic [7:0] MASK_ALL = 8'hFF;

	// Opcodes of the control bytes.
	localparam logic [7:0] OP_DISPLAY_ONOFF = 8'hAE;
	localparam logic [7:0] OP_START_LINE = 8'h40;
	localparam logic [7:0] OP_PAGE = 8'hB0;
	localparam logic [7:0] OP_COL_UPPER = 8'h10;
	localparam logic [7:0] OP_COL_LOWER = 8'h00;
	localparam logic [7:0] OP_SEG_DIR = 8'hA0;
	localparam logic [7:0] OP_INVERT = 8'hA6;
	localparam logic [7:0] OP_ALL_POINTS = 8'hA4;
	localparam logic [7:0] OP_BIAS = 8'hA2;
	localparam logic [7:0] OP_RMW = 8'hE0;
	localparam logic [7:0] OP_END = 8'hEE;
	localparam logic [7:0] OP_SOFT_RESET = 8'hE2;
	localparam logic [7:0] OP_COM_DIR = 8'hC0;
	localparam logic [7:0] OP_POWER = 8'h28;
	localparam logic [7:0] OP_RATIO = 8'h20;
	localparam logic [7:0] OP_VOLUME_MODE = 8'h81;
	localparam logic [7:0] OP_INDICATOR = 8'hAC;

	// Field widths and positions.
	localparam int PAGE_W = 4;
	localparam int COL_W = 8;
	localparam int COM_DIR_BIT = 3;
	localparam int STAT_SEG_DIR_BIT = 6;
	localparam int STAT_OFF_BIT = 5;
	localparam int STAT_RESET_BIT = 4;

	// Reset values of the addressing state.
	localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
	localparam logic [COL_W-1:0] COL_RESET = 8'h00;

	// Panel settings that leave the block together.
	typedef struct packed {
		logic display_on;
		logic seg_reverse;
		logic invert;
		logic all_points;
		logic bias_select;
		logic common_reverse;
		logic [5:0] start_line;
		logic [2:0] power_mode;
		logic [2:0] resistor_ratio;
		logic [5:0] contrast;
		logic indicator_on;
		logic [1:0] indicator_mode;
	} panel_settings_t;

	localparam panel_settings_t SETTINGS_RESET = '{
		display_on: 1'b0, seg_reverse: 1'b0, invert: 1'b0, all_points: 1'b0,
		bias_select: 1'b0, common_reverse: 1'b0, start_line: 6'h00,
		power_mode: 3'h0, resistor_ratio: 3'h0, contrast: 6'h20,
		indicator_on: 1'b0, indicator_mode: 2'h0};

	// Decoder states: plain commands, or waiting for a second byte.
	typedef enum logic [1:0] {
		ST_COMMAND = 2'b00,
		ST_VOLUME = 2'b01,
		ST_INDICATOR = 2'b10
	} cmd_state_t;

endpackage : lcd_port_pkg

// ==== pin_sync.sv ====
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes the pins are independent levels; the first stage is read
 * by the second stage only, so metastability never reaches logic.
 */
`timescale 1ns/10ps
module pin_sync
#(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VALUE = '0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	// First stage, read only by the second stage.
	logic [W-1:0] stage1_reg;

	// Both stages reset to the idle level of each pin.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stage1_reg <= RESET_VALUE;
			pin_out <= RESET_VALUE;
		end
		else
		begin
			stage1_reg <= pin_in;
			pin_out <= stage1_reg;
		end
	end

endmodule : pin_sync

// ==== lcd_port_sva.sv ====
/*
 * Checker of the display host port: read drive, reset hold, scan and status.
 * Assumes host pins change just after SYS_CLK edges and pass two sync stages.
 */
`timescale 1ns/10ps
module lcd_port_sva
	import lcd_port_pkg::*;
#(
	parameter int PAGES = 8,
	parameter int COLUMNS = 128
)
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CHIP_SELECT_N,
	input wire logic DATA_COMMAND_SELECT,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic BUS_STYLE_STRAP,
	input wire logic HARDWARE_RESET_N,
	input wire logic [7:0] HOST_DATA_IN,
	input wire logic [7:0] HOST_DATA_OUT,
	input wire logic HOST_DATA_OE,
	input wire panel_settings_t SETTINGS,
	input wire logic [PAGE_W-1:0] PAGE_ADDRESS,
	input wire logic [COL_W-1:0] COLUMN_ADDRESS,
	input wire logic RMW_ACTIVE,
	input wire logic [PAGE_W-1:0] SCAN_PAGE,
	input wire logic [COL_W-1:0] SCAN_COLUMN,
	input wire logic [7:0] SCAN_DATA
);
	// Four samples cover two sync stages plus the output register.
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// Read active in each bus style.
	wire logic pair_rd = !CHIP_SELECT_N && !BUS_STYLE_STRAP && !READ_STROBE_N;
	wire logic en_rd = !CHIP_SELECT_N && BUS_STYLE_STRAP && READ_STROBE_N && WRITE_STROBE_N;
	wire logic pair_idle = !BUS_STYLE_STRAP && READ_STROBE_N;
	wire logic hw_low = !HARDWARE_RESET_N;
	rd_drive_a: assert property (pair_rd [*4] |-> HOST_DATA_OE)
		else $error("bus not driven during read");
	rd_idle_a: assert property (pair_idle [*4] |-> !HOST_DATA_OE)
		else $error("bus driven without read");
	cs_block_a: assert property (CHIP_SELECT_N [*4] |-> !HOST_DATA_OE)
		else $error("bus driven while deselected");
	en_read_a: assert property (en_rd [*4] |-> HOST_DATA_OE)
		else $error("enable style read not driven");
	hw_hold_a: assert property (hw_low [*4] |-> SETTINGS == SETTINGS_RESET
		&& PAGE_ADDRESS == PAGE_RESET && COLUMN_ADDRESS == COL_RESET && !RMW_ACTIVE)
		else $error("state moved under hardware reset");
	dark_scan_a: assert property (!$past(SETTINGS.display_on) |-> SCAN_DATA == 8'h00)
		else $error("scan shows data while off");
	all_on_a: assert property ($past(SETTINGS.display_on) && $past(SETTINGS.all_points)
		|-> SCAN_DATA == 8'hFF) else $error("all points not forced");
	status_byte_a: assert property ($rose(HOST_DATA_OE) && !$past(DATA_COMMAND_SELECT, 3)
		|-> HOST_DATA_OUT[7] == 1'b0 && HOST_DATA_OUT[3:0] == 4'h0
		&& HOST_DATA_OUT[6] == SETTINGS.seg_reverse && HOST_DATA_OUT[5] == !SETTINGS.display_on)
		else $error("status byte wrong");
	rmw_hold_a: assert property ($fell(HOST_DATA_OE) && RMW_ACTIVE
		|-> $stable(COLUMN_ADDRESS) [*2]) else $error("column moved on rmw read");
	col_range_a: assert property (COLUMN_ADDRESS < COLUMNS)
		else $error("column beyond last");
	cover property (RMW_ACTIVE && HOST_DATA_OE);
	cover property (en_rd [*4]);
	cover property ($past(SETTINGS.invert) && SCAN_DATA != 8'h00);
endmodule : lcd_port_sva

bind lcd_host_port_command_decoder lcd_port_sva #(.PAGES(PAGES), .COLUMNS(COLUMNS)) sva_u (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CHIP_SELECT_N(CHIP_SELECT_N),
	.DATA_COMMAND_SELECT(DATA_COMMAND_SELECT), .WRITE_STROBE_N(WRITE_STROBE_N),
	.READ_STROBE_N(READ_STROBE_N), .BUS_STYLE_STRAP(BUS_STYLE_STRAP),
	.HARDWARE_RESET_N(HARDWARE_RESET_N), .HOST_DATA_IN(HOST_DATA_IN),
	.HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE(HOST_DATA_OE), .SETTINGS(SETTINGS),
	.PAGE_ADDRESS(PAGE_ADDRESS), .COLUMN_ADDRESS(COLUMN_ADDRESS), .RMW_ACTIVE(RMW_ACTIVE),
	.SCAN_PAGE(SCAN_PAGE), .SCAN_COLUMN(SCAN_COLUMN), .SCAN_DATA(SCAN_DATA));

// ==== lcd_host_model.sv ====
/*
 * Host processor model on the parallel port, both bus styles.
 * Assumes the bench resolves the data wire from both drivers.
 */
`timescale 1ns/10ps
module lcd_host_model
(
	input wire logic clk,
	input wire logic strap,
	input wire logic [7:0] bus_in,
	output logic cs_n,
	output logic dc,
	output logic wr_n,
	output logic rd_n,
	output logic [7:0] bus_drive
);
	logic [7:0] drv; // Last byte put on the wire.
	logic drv_en; // High while the host drives the wire.
	// Released wire shows the inverse, so a stale byte never matches.
	assign bus_drive = drv_en ? drv : ~drv;
	initial
	begin
		cs_n = 1'b1;
		dc = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		drv = 8'h00;
		drv_en = 1'b0;
	end
	// One transfer; wr_n is write strobe or direction, rd_n read strobe or enable, by style.
	task xfer(input logic rd, input logic dc_v, input logic [7:0] d, input logic sel_n,
		output logic [7:0] q);
		@(posedge clk);
		cs_n <= sel_n;
		dc <= dc_v;
		drv <= d;
		drv_en <= !rd;
		wr_n <= rd;
		rd_n <= strap | !rd;
		repeat (4) @(posedge clk);
		q = bus_in;
		wr_n <= 1'b1;
		rd_n <= !strap;
		// data held past the strobe end
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		drv_en <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask : xfer
endmodule : lcd_host_model

// ==== testbench.sv ====
/*
 * Self-checking bench of the display host port decoder.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/10ps
module testbench
	import lcd_port_pkg::*;
;
	logic clk, rst, strap, hw_n, oe, rmw;
	logic [3:0] spage, page;
	logic [7:0] scol, col, sdat, dout, drive, q;
	wire logic cs_n, dc, wr_n, rd_n;
	panel_settings_t st;
	int miscompares, checks, cyc;
	// The device wins the wire while it drives it.
	wire logic [7:0] bus_w = oe ? dout : drive;
	lcd_host_model host_u (.clk(clk), .strap(strap), .bus_in(bus_w), .cs_n(cs_n), .dc(dc),
		.wr_n(wr_n), .rd_n(rd_n), .bus_drive(drive));
	lcd_host_port_command_decoder dut_u (.SYS_CLK(clk), .SYS_RST(rst), .CHIP_SELECT_N(cs_n),
		.DATA_COMMAND_SELECT(dc), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
		.BUS_STYLE_STRAP(strap), .HARDWARE_RESET_N(hw_n), .HOST_DATA_IN(bus_w),
		.HOST_DATA_OUT(dout), .HOST_DATA_OE(oe), .SETTINGS(st), .PAGE_ADDRESS(page),
		.COLUMN_ADDRESS(col), .RMW_ACTIVE(rmw), .SCAN_PAGE(spage), .SCAN_COLUMN(scol),
		.SCAN_DATA(sdat));
	// Free-running 200 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task results;
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task cmd(input logic [7:0] d);
		host_u.xfer(1'b0, 1'b0, d, 1'b0, q);
	endtask : cmd
	task col_to(input logic [7:0] c);
		cmd({4'h1, c[7:4]});
		cmd({4'h0, c[3:0]});
	endtask : col_to
	task t_settings;
		logic [7:0] seq [17];
		panel_settings_t e;
		seq = '{8'hAF, 8'h7F, 8'hB5, 8'h13, 8'h0A, 8'hA1, 8'hA7, 8'hA5, 8'hA3, 8'hC8,
			8'h2F, 8'h25, 8'h81, 8'h15, 8'hAD, 8'h02, 8'hB2};
		e = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 6'h3F, 3'h7, 3'h5, 6'h15, 1'b1, 2'h2};
		foreach (seq[i])
			cmd(seq[i]);
		chk(st, e);
		chk(page, 4'h2);
		col_to(8'h04);
		chk(col, 8'h04);
	endtask : t_settings
	task t_data;
		host_u.xfer(1'b0, 1'b1, 8'hAA, 1'b0, q);
		host_u.xfer(1'b0, 1'b1, 8'h55, 1'b0, q);
		chk(col, 8'h06);
		col_to(8'h04);
		host_u.xfer(1'b1, 1'b1, 8'h00, 1'b0, q);
		chk(q, 8'hAA);
		host_u.xfer(1'b1, 1'b1, 8'h00, 1'b0, q);
		chk(q, 8'h55);
		chk(col, 8'h06);
		host_u.xfer(1'b1, 1'b0, 8'h00, 1'b0, q);
		chk(q, 8'h40);
		// Reversed segments put column 4 at scan column 8'h7B, four from the far end.
		@(posedge clk);
		spage <= 4'h2;
		scol <= 8'h7B;
		cmd(8'hA4);
		chk(sdat, 8'h55);
		cmd(8'hA6);
		chk(sdat, 8'hAA);
		cmd(8'hA0);
		@(posedge clk);
		scol <= 8'h04;
		@(posedge clk);
		@(posedge clk);
		#1;
		chk(sdat, 8'hAA);
	endtask : t_data
	task t_rmw;
		col_to(8'h04);
		cmd(8'hE0);
		chk(rmw, 1'b1);
		host_u.xfer(1'b1, 1'b1, 8'h00, 1'b0, q);
		chk(col, 8'h04);
		host_u.xfer(1'b0, 1'b1, 8'h5A, 1'b0, q);
		chk(col, 8'h05);
		cmd(8'hEE);
		chk(rmw, 1'b0);
		col_to(8'h04);
		host_u.xfer(1'b1, 1'b1, 8'h00, 1'b0, q);
		chk(q, 8'h5A);
	endtask : t_rmw
	task t_style;
		host_u.xfer(1'b0, 1'b0, 8'hAE, 1'b1, q);
		chk(st.display_on, 1'b1);
		@(posedge clk);
		strap <= 1'b1;
		host_u.rd_n <= 1'b0;
		repeat (4) @(posedge clk);
		cmd(8'hAE);
		chk(st.display_on, 1'b0);
		host_u.xfer(1'b1, 1'b0, 8'h00, 1'b0, q);
		chk(q, 8'h20);
		cmd(8'hAF);
		@(posedge clk);
		strap <= 1'b0;
		host_u.rd_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : t_style
	task t_resets;
		cmd(8'hB3);
		cmd(8'hE2);
		chk({page, col, st.contrast, st.start_line, st.display_on}, {12'h000, 6'h20, 6'h00, 1'b1});
		@(posedge clk);
		hw_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk(st, SETTINGS_RESET);
		@(posedge clk);
		hw_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : t_resets
	// Cuts a hang short well above the expected run length.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			miscompares++;
			results();
		end
	end
	initial
	begin
		rst = 1'b1;
		strap = 1'b0;
		hw_n = 1'b1;
		spage = 4'h0;
		scol = 8'h00;
		miscompares = 0;
		checks = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_settings();
		t_data();
		t_rmw();
		t_style();
		t_resets();
		results();
	end
endmodule : testbench
